// ### sap_bus_counter.sv
// partner model: timer-capture counter on the first column comparator bus
// assumes: busIn is a level synchronous to clock
`timescale 1ns/100ps

module sap_bus_counter (
  input wire logic clock,
  input wire logic rstn,
  input wire logic busIn,
  output logic [15:0] captureCount
);
  logic prev_ff;
  logic [15:0] count_ff;
  assign captureCount = count_ff;
  // counts rising edges of the bus, as a capture timer would
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prev_ff <= 1'b0;
      count_ff <= 16'h0000;
    end else begin
      prev_ff <= busIn;
      if (busIn && !prev_ff) begin
        count_ff <= count_ff + 16'h0001;
      end
    end
  end
endmodule

// ### sap_column_clock_div.sv
// column clock divider: passes one of every 1, 2, 4 or 8 source ticks
// assumes: tickIn is a one-cycle pulse per selected source clock edge
`timescale 1ns/100ps
`include "sap_defines.svh"

module sap_column_clock_div (
  input wire logic clock,
  input wire logic rstn,
  input wire logic tickIn,
  input wire logic [1:0] divideCode,
  output logic tickOut
);

  sap_pkg::sap_div_state_t st_ff;
  sap_pkg::sap_div_state_t nxt_st;
  logic [2:0] limit;

  // last count before an output tick
  assign limit = 3'((4'h1 << divideCode) - 4'h1);

  // count source ticks, emit one per ratio
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (tickIn) begin
      if (st_ff.count >= limit) begin
        nxt_st.count = 3'h0;
        nxt_st.tick = 1'b1;
      end else begin
        nxt_st.count = 3'(st_ff.count + 3'h1);
      end
    end
  end

  // state register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tickOut = st_ff.tick;

endmodule

// ### sap_converter_ctrl.sv
// single-slope converter control for two extra analog columns, AXI4-Lite register slave
// assumes: all clock and comparator inputs are levels synchronous to clock
//
// Functional notes
// - on-span zero: gating comes from digital block output picked by select bits
// - on-span codes 1..5 give 1, 2, 4, 8, 16 third-clock periods high
// - off-span zero: no low time, only terminal count pulses
// - off-span codes 1..3 hold pwm low 1, 2 or 3 third-clock periods
// - dedicated pwm runs only while its enable bit 0 is set
// - nonzero on-span makes dedicated pwm the gating source, overriding digital blocks
// - each comparator bus is gated only when its enable bit in 7:4 is set
// - comparator state captured at gating fall, or at terminal count when off-span is zero, read back as bit 7
// - bit 6 picks normal or roughly four times lower current range
// - bit 5 enables sample-and-hold on the positive input
// - bit 3 picks gated synced comparator or pwm terminal count for bus
// - bit 2 lets the selected pwm drive ramp generator and sample-and-hold
// - bit 0 powers and enables the column converter
// - clock-select fields: bits 3:2 second column, bits 1:0 first column
// - clock-select codes pick variable one, variable two, analog four, analog five
// - column clock is selected clock divided by the divider register ratio
// - divide codes mean 1, 2, 4 and 8
// - system-clock-direct bit takes column clock from system clock, ignoring select
// - four-bit field 3:0 picks modulator bits for the second column
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "sap_defines.svh"

module sap_converter_ctrl #(
  parameter int ADDR_W = 12
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic variable_clock_one,
  input wire logic variable_clock_two,
  input wire logic variable_clock_three,
  input wire logic analog_clock_four,
  input wire logic analog_clock_five,
  input wire logic [3:0] digitalGate,
  input wire logic [1:0] comparatorIn,
  output sap_pkg::sap_column_out_t [1:0] columnOut,
  output logic [1:0] columnClockTick,
  output logic [3:0] second_column_modulator_bits,
  output logic conversionPwm,
  output logic pwmTerminalCount
);

  // refuse address widths that cannot reach the top register or exceed the bus
  if (ADDR_W < 10 || ADDR_W > 12) begin : g_bad_addr
    $error("sap_converter_ctrl: ADDR_W must be 10 to 12");
  end

  sap_pkg::sap_state_t st_ff;
  sap_pkg::sap_state_t nxt_st;
  logic [2:0] onCode;
  logic [1:0] lowCode;
  logic pwmSelected;
  logic pwmActive;
  logic vc3Rise;
  logic gate;
  logic gateFall;
  logic selectedTc;
  logic endEvent;
  logic [4:0] highLen;
  logic [4:0] lowLen;
  logic [3:0] srcLevels;
  logic [3:0] srcRise;
  logic [1:0] colTickIn;
  logic [1:0] hit;
  sap_pkg::sap_reg_t wrSel;
  sap_pkg::sap_reg_t rdSel;

  // register picked by a bus address; unaligned or unknown gives none
  function automatic sap_pkg::sap_reg_t regDecode(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-3:0] idx;
    idx = addr[ADDR_W-1:2];
    regDecode = sap_pkg::SAP_REG_NONE;
    if (addr[1:0] == 2'h0) begin
      case (idx)
        (ADDR_W-2)'(`SAP_IDX_MODULATOR): regDecode = sap_pkg::SAP_REG_MODULATOR;
        (ADDR_W-2)'(`SAP_IDX_PWM): regDecode = sap_pkg::SAP_REG_PWM;
        (ADDR_W-2)'(`SAP_IDX_COL_A): regDecode = sap_pkg::SAP_REG_COL_A;
        (ADDR_W-2)'(`SAP_IDX_COL_B): regDecode = sap_pkg::SAP_REG_COL_B;
        (ADDR_W-2)'(`SAP_IDX_CLK_SEL): regDecode = sap_pkg::SAP_REG_CLK_SEL;
        (ADDR_W-2)'(`SAP_IDX_CLK_DIV): regDecode = sap_pkg::SAP_REG_CLK_DIV;
        (ADDR_W-2)'(`SAP_IDX_GATE_CTRL): regDecode = sap_pkg::SAP_REG_GATE_CTRL;
        (ADDR_W-2)'(`SAP_IDX_GATE_SRC): regDecode = sap_pkg::SAP_REG_GATE_SRC;
        default: regDecode = sap_pkg::SAP_REG_NONE;
      endcase
    end
  endfunction

  // high span in third-clock periods; reserved codes give zero
  function automatic logic [4:0] highSpan(input logic [2:0] code);
    case (code)
      3'h1: highSpan = 5'h01;
      3'h2: highSpan = 5'h02;
      3'h3: highSpan = 5'h04;
      3'h4: highSpan = 5'h08;
      3'h5: highSpan = 5'h10;
      default: highSpan = 5'h00;
    endcase
  endfunction

  // pwm field decode and gating source choice
  assign onCode = st_ff.pwmCtrl[`SAP_PWM_ON_LSB +: 3];
  assign lowCode = st_ff.pwmCtrl[`SAP_PWM_LOW_LSB +: 2];
  assign highLen = highSpan(onCode);
  assign lowLen = {3'h0, lowCode};
  assign pwmSelected = (onCode != 3'h0);
  assign pwmActive = st_ff.pwmCtrl[`SAP_PWM_EN_BIT] && (highLen != 5'h00);
  assign vc3Rise = variable_clock_three && !st_ff.vc3Prev;
  assign gate = pwmSelected ? st_ff.pwmLevel : digitalGate[st_ff.gateSrc[1:0]];
  assign gateFall = st_ff.gatePrev && !gate;
  assign selectedTc = pwmSelected ? st_ff.pwmTc : gateFall;
  // without a low span the gate never falls, so the terminal count ends the period
  assign endEvent = gateFall || (pwmSelected && st_ff.pwmTc && lowCode == 2'h0);
  assign wrSel = regDecode(st_ff.awAddr[ADDR_W-1:0]);
  assign rdSel = regDecode(araddr);

  // bus handshakes: one write and one read at a time
  assign awready = !st_ff.awHeld && !st_ff.bvalid;
  assign wready = !st_ff.wHeld && !st_ff.bvalid;
  assign arready = !st_ff.rvalid;

  // column clock sources: order matches the clock-select codes
  assign srcLevels = {analog_clock_five, analog_clock_four, variable_clock_two,
    variable_clock_one};
  assign srcRise = srcLevels & ~st_ff.srcPrev;

  // per-column clock source pick and divider
  for (genvar c = 0; c < 2; c++) begin : g_col_clk
    assign colTickIn[c] = st_ff.clkDiv[4*c + `SAP_DIV_SYS_BIT] ? 1'b1 :
      srcRise[st_ff.clkSel[2*c +: 2]];
    sap_column_clock_div u_div (
      .clock(clock),
      .rstn(rstn),
      .tickIn(colTickIn[c]),
      .divideCode(st_ff.clkDiv[4*c +: 2]),
      .tickOut(columnClockTick[c])
    );
    // comparator seen high while gated during this ramp
    assign hit[c] = comparatorIn[c] && gate && st_ff.adcCfg[c][`SAP_COL_PWR_BIT];
  end

  // next state: pwm, registers, bus, column control
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pwmTc = 1'b0;
    nxt_st.vc3Prev = variable_clock_three;
    nxt_st.gatePrev = gate;
    nxt_st.srcPrev = srcLevels;

    // dedicated pwm: high span, optional low span, terminal count per cycle
    case (st_ff.pwmState)
      sap_pkg::SAP_PWM_IDLE: begin
        nxt_st.pwmLevel = 1'b0;
        nxt_st.spanCnt = 5'h00;
        if (pwmActive) begin
          nxt_st.pwmState = sap_pkg::SAP_PWM_HIGH;
          nxt_st.pwmLevel = 1'b1;
        end
      end
      sap_pkg::SAP_PWM_HIGH: begin
        if (!pwmActive) begin
          nxt_st.pwmState = sap_pkg::SAP_PWM_IDLE;
          nxt_st.pwmLevel = 1'b0;
        end else if (vc3Rise) begin
          if (5'(st_ff.spanCnt + 5'h01) >= highLen) begin
            nxt_st.spanCnt = 5'h00;
            if (lowCode == 2'h0) begin
              nxt_st.pwmTc = 1'b1;
            end else begin
              nxt_st.pwmState = sap_pkg::SAP_PWM_LOW;
              nxt_st.pwmLevel = 1'b0;
            end
          end else begin
            nxt_st.spanCnt = 5'(st_ff.spanCnt + 5'h01);
          end
        end
      end
      sap_pkg::SAP_PWM_LOW: begin
        if (!pwmActive) begin
          nxt_st.pwmState = sap_pkg::SAP_PWM_IDLE;
          nxt_st.pwmLevel = 1'b0;
        end else if (vc3Rise) begin
          if (5'(st_ff.spanCnt + 5'h01) >= lowLen) begin
            nxt_st.spanCnt = 5'h00;
            nxt_st.pwmTc = 1'b1;
            nxt_st.pwmState = sap_pkg::SAP_PWM_HIGH;
            nxt_st.pwmLevel = 1'b1;
          end else begin
            nxt_st.spanCnt = 5'(st_ff.spanCnt + 5'h01);
          end
        end
      end
      default: begin
        nxt_st.pwmState = sap_pkg::SAP_PWM_IDLE;
        nxt_st.pwmLevel = 1'b0;
      end
    endcase

    // write: finish when address and data are both held
    if (st_ff.awHeld && st_ff.wHeld && !st_ff.bvalid) begin
      nxt_st.awHeld = 1'b0;
      nxt_st.wHeld = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = (wrSel == sap_pkg::SAP_REG_NONE) ? `SAP_RESP_SLVERR : `SAP_RESP_OKAY;
      if (st_ff.wStrb0) begin
        // reserved bits are masked off so they always read back zero
        case (wrSel)
          sap_pkg::SAP_REG_MODULATOR: nxt_st.modSel = st_ff.wData & `SAP_MASK_MODULATOR;
          sap_pkg::SAP_REG_PWM: nxt_st.pwmCtrl = st_ff.wData & `SAP_MASK_PWM;
          sap_pkg::SAP_REG_COL_A: nxt_st.adcCfg[0] = st_ff.wData & `SAP_MASK_COL;
          sap_pkg::SAP_REG_COL_B: nxt_st.adcCfg[1] = st_ff.wData & `SAP_MASK_COL;
          sap_pkg::SAP_REG_CLK_SEL: nxt_st.clkSel = st_ff.wData & `SAP_MASK_CLK_SEL;
          sap_pkg::SAP_REG_CLK_DIV: nxt_st.clkDiv = st_ff.wData & `SAP_MASK_CLK_DIV;
          sap_pkg::SAP_REG_GATE_CTRL: nxt_st.gateCtrl = st_ff.wData & `SAP_MASK_GATE_CTRL;
          sap_pkg::SAP_REG_GATE_SRC: nxt_st.gateSrc = st_ff.wData & `SAP_MASK_GATE_SRC;
          default: nxt_st.modSel = st_ff.modSel;
        endcase
      end
    end
    if (awvalid && awready) begin
      nxt_st.awHeld = 1'b1;
      nxt_st.awAddr = 12'(awaddr);
    end
    if (wvalid && wready) begin
      nxt_st.wHeld = 1'b1;
      nxt_st.wData = wdata[7:0];
      nxt_st.wStrb0 = wstrb[0];
    end
    if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // read: data captured at the address handshake
    if (arvalid && arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = `SAP_RESP_OKAY;
      case (rdSel)
        sap_pkg::SAP_REG_MODULATOR: nxt_st.rdata = st_ff.modSel;
        sap_pkg::SAP_REG_PWM: nxt_st.rdata = st_ff.pwmCtrl;
        sap_pkg::SAP_REG_COL_A: nxt_st.rdata = {st_ff.endState[0], st_ff.adcCfg[0][6:0]};
        sap_pkg::SAP_REG_COL_B: nxt_st.rdata = {st_ff.endState[1], st_ff.adcCfg[1][6:0]};
        sap_pkg::SAP_REG_CLK_SEL: nxt_st.rdata = st_ff.clkSel;
        sap_pkg::SAP_REG_CLK_DIV: nxt_st.rdata = st_ff.clkDiv;
        sap_pkg::SAP_REG_GATE_CTRL: nxt_st.rdata = st_ff.gateCtrl;
        sap_pkg::SAP_REG_GATE_SRC: nxt_st.rdata = st_ff.gateSrc;
        default: begin
          nxt_st.rdata = 8'h00;
          nxt_st.rresp = `SAP_RESP_SLVERR;
        end
      endcase
    end else if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
    end

    // per-column comparator capture, bus source and analog controls
    for (int i = 0; i < 2; i++) begin
      nxt_st.cmpSync[i] = comparatorIn[i] &&
        (st_ff.gateCtrl[`SAP_GATE_EN_LSB + i] ? gate : 1'b1);
      if (endEvent) begin
        nxt_st.endState[i] = st_ff.tripSeen[i] || hit[i];
        nxt_st.tripSeen[i] = 1'b0;
      end else if (hit[i]) begin
        nxt_st.tripSeen[i] = 1'b1;
      end
      nxt_st.colOut[i].busOut = st_ff.adcCfg[i][`SAP_COL_BUS_BIT] ? selectedTc :
        st_ff.cmpSync[i];
      nxt_st.colOut[i].powerOn = st_ff.adcCfg[i][`SAP_COL_PWR_BIT];
      nxt_st.colOut[i].lowRange = st_ff.adcCfg[i][`SAP_COL_RANGE_BIT];
      nxt_st.colOut[i].sampleHold = st_ff.adcCfg[i][`SAP_COL_SH_BIT] &&
        st_ff.adcCfg[i][`SAP_COL_PWR_BIT] &&
        (st_ff.adcCfg[i][`SAP_COL_AUTO_BIT] ? gate : 1'b1);
      nxt_st.colOut[i].rampDrive = st_ff.adcCfg[i][`SAP_COL_PWR_BIT] &&
        st_ff.adcCfg[i][`SAP_COL_AUTO_BIT] && gate;
    end
  end

  // state register; everything clears at reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign rvalid = st_ff.rvalid;
  assign rdata = {24'h000000, st_ff.rdata};
  assign rresp = st_ff.rresp;
  assign columnOut = st_ff.colOut;
  assign second_column_modulator_bits = st_ff.modSel[3:0];
  assign conversionPwm = st_ff.pwmLevel;
  assign pwmTerminalCount = st_ff.pwmTc;

  // pwm held low once disabled
  a_pwm_disabled_low: assert property (@(posedge clock) disable iff (!rstn)
    !st_ff.pwmCtrl[`SAP_PWM_EN_BIT] |=> !st_ff.pwmLevel)
    else $error("pwm high while disabled");

  // end of high span drops the pwm when a low span exists
  a_high_span_end: assert property (@(posedge clock) disable iff (!rstn)
    (st_ff.pwmState == sap_pkg::SAP_PWM_HIGH && pwmActive && vc3Rise && lowCode != 2'h0
      && 5'(st_ff.spanCnt + 5'h01) == highLen) |=> !st_ff.pwmLevel)
    else $error("high span not ended on time");

  // end of low span gives terminal count and new high
  a_low_span_tc: assert property (@(posedge clock) disable iff (!rstn)
    (st_ff.pwmState == sap_pkg::SAP_PWM_LOW && pwmActive && vc3Rise
      && 5'(st_ff.spanCnt + 5'h01) == lowLen) |=> (st_ff.pwmTc && st_ff.pwmLevel))
    else $error("low span end without terminal count");

  // no low phase when the off span is zero
  a_no_low_phase: assert property (@(posedge clock) disable iff (!rstn)
    (pwmActive && lowCode == 2'h0 && st_ff.pwmState != sap_pkg::SAP_PWM_LOW)
      |=> st_ff.pwmState != sap_pkg::SAP_PWM_LOW)
    else $error("low phase entered with zero off span");

  // ramp follows the digital block gate when on span is zero
  a_gate_digital: assert property (@(posedge clock) disable iff (!rstn)
    (onCode == 3'h0 && st_ff.adcCfg[0][`SAP_COL_PWR_BIT] && st_ff.adcCfg[0][`SAP_COL_AUTO_BIT])
      |=> columnOut[0].rampDrive == $past(digitalGate[st_ff.gateSrc[1:0]]))
    else $error("gate not from digital block");

  // dedicated pwm overrides gating source for the ramp
  a_gate_override: assert property (@(posedge clock) disable iff (!rstn)
    (onCode != 3'h0 && st_ff.adcCfg[0][`SAP_COL_PWR_BIT] && st_ff.adcCfg[0][`SAP_COL_AUTO_BIT])
      |=> columnOut[0].rampDrive == $past(st_ff.pwmLevel))
    else $error("gate not from dedicated pwm");

  // gated comparator held low while gate is low
  a_gate_enable: assert property (@(posedge clock) disable iff (!rstn)
    (st_ff.gateCtrl[`SAP_GATE_EN_LSB] && !gate) |=> !st_ff.cmpSync[0])
    else $error("comparator passed while gated off");

  // a trip seen during the ramp is latched at its end
  a_end_capture: assert property (@(posedge clock) disable iff (!rstn)
    (endEvent && st_ff.tripSeen[0]) |=> (st_ff.endState[0] && !st_ff.tripSeen[0]))
    else $error("trip not captured at conversion end");

  // timer capture mode forwards the terminal count
  a_bus_source: assert property (@(posedge clock) disable iff (!rstn)
    (st_ff.adcCfg[0][`SAP_COL_BUS_BIT] && $stable(st_ff.adcCfg[0]))
      |=> st_ff.colOut[0].busOut == $past(selectedTc))
    else $error("bus not driven by terminal count");

  // system clock direct with no divide ticks every cycle
  a_clock_direct: assert property (@(posedge clock) disable iff (!rstn)
    (st_ff.clkDiv[6:4] == 3'h4) [*2] |-> columnClockTick[1])
    else $error("direct column clock missing tick");

  // converter power follows its enable bit
  a_power_off: assert property (@(posedge clock) disable iff (!rstn)
    !st_ff.adcCfg[1][`SAP_COL_PWR_BIT] |=> !columnOut[1].powerOn && !columnOut[1].rampDrive)
    else $error("converter powered while disabled");

endmodule

// ### sap_converter_ctrl_tb_top.sv
// testbench: register bus, pwm spans, end state, bus source, column clocks
// assumes: sap_converter_ctrl and sap_bus_counter are compiled before it
`timescale 1ns/100ps
`include "sap_defines.svh"

module sap_converter_ctrl_tb_top;
  logic clock, rstn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, conversionPwm, pwmTerminalCount;
  logic variable_clock_one, variable_clock_two, variable_clock_three;
  logic analog_clock_four, analog_clock_five;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, digitalGate, second_column_modulator_bits;
  logic [2:0] awprot, arprot;
  logic [1:0] bresp, rresp, comparatorIn, columnClockTick, rsp;
  logic [15:0] captureCount, c0;
  logic [7:0] d;
  sap_pkg::sap_column_out_t [1:0] columnOut;
  int errCount, samplesChecked, cyc, g, hiT;
  logic [7:0] idx [8] = '{`SAP_IDX_MODULATOR, `SAP_IDX_PWM, `SAP_IDX_COL_A, `SAP_IDX_COL_B,
    `SAP_IDX_CLK_SEL, `SAP_IDX_CLK_DIV, `SAP_IDX_GATE_CTRL, `SAP_IDX_GATE_SRC};
  logic [7:0] msk [8] = '{`SAP_MASK_MODULATOR, `SAP_MASK_PWM, `SAP_MASK_COL, `SAP_MASK_COL,
    `SAP_MASK_CLK_SEL, `SAP_MASK_CLK_DIV, `SAP_MASK_GATE_CTRL, `SAP_MASK_GATE_SRC};

  sap_converter_ctrl dut (.clock, .rstn, .awvalid, .awready, .awaddr, .awprot, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
    .rvalid, .rready, .rdata, .rresp, .variable_clock_one, .variable_clock_two,
    .variable_clock_three, .analog_clock_four, .analog_clock_five, .digitalGate,
    .comparatorIn, .columnOut, .columnClockTick, .second_column_modulator_bits,
    .conversionPwm, .pwmTerminalCount);
  sap_bus_counter partner (.clock, .rstn, .busIn(columnOut[0].busOut), .captureCount);

  // system clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // source clocks of periods 4, 8, 16, 32 cycles, random gates, watchdog
  always @(posedge clock) begin
    cyc <= cyc + 1;
    variable_clock_one <= cyc[1];
    variable_clock_two <= cyc[2];
    variable_clock_three <= cyc[1];
    analog_clock_four <= cyc[3];
    analog_clock_five <= cyc[4];
    digitalGate <= 4'($urandom);
    if (cyc == 100000) begin
      errCount++;
      finishTest();
    end
  end

  task automatic finishTest();
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("Error %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // bus write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clock);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awaddr <= {2'h0, i, 2'h0};
    wdata <= {24'h000000, v};
    wstrb <= 4'hF;
    while (!(ta && tw)) begin
      @(negedge clock);
      if (awvalid && awready) ta = 1'b1;
      if (wvalid && wready) tw = 1'b1;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(negedge clock); while (!bvalid);
    rsp = bresp;
    @(posedge clock);
    bready <= 1'b0;
  endtask

  // bus read: holds the request until taken, ready until data seen
  task automatic rdr(input logic [7:0] i);
    logic t;
    t = 1'b0;
    @(posedge clock);
    arvalid <= 1'b1;
    araddr <= {2'h0, i, 2'h0};
    rready <= 1'b1;
    while (!t) begin
      @(negedge clock);
      t = arready;
      @(posedge clock);
    end
    arvalid <= 1'b0;
    do @(negedge clock); while (!rvalid);
    rd = rdata;
    rsp = rresp;
    @(posedge clock);
    rready <= 1'b0;
  endtask

  function automatic logic sig(input int k);
    return (k == 0) ? pwmTerminalCount : columnClockTick[k-1];
  endfunction

  // cycles between two pulses after alignment, with pwm high time
  task automatic gap(input int k, output int n);
    do @(negedge clock); while (!sig(k));
    repeat (2) begin
      n = 0;
      hiT = 0;
      do begin
        @(negedge clock);
        n++;
        if (conversionPwm) hiT++;
      end while (!sig(k));
    end
  endtask

  // main sequence
  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    {awprot, arprot, comparatorIn, digitalGate, cyc, errCount, samplesChecked} = '0;
    {variable_clock_one, variable_clock_two, variable_clock_three} = '0;
    {analog_clock_four, analog_clock_five} = '0;
    d = 8'($urandom(2458));
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rdr(idx[i]);
      chk(rd, 32'h00000000);
    end
    rdr(8'h84);
    chk(rd, 32'h00000000);
    chk(rsp, `SAP_RESP_SLVERR);
    wr(8'h84, 8'hFF);
    chk(rsp, `SAP_RESP_SLVERR);
    $display("reset and map test done");
    repeat (3) for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      wr(idx[i], d);
      rdr(idx[i]);
      @(negedge clock);
      chk(rd & ((i == 2 || i == 3) ? 32'h7F : 32'hFF), d & msk[i]);
      if (i == 0) chk(second_column_modulator_bits, d[3:0]);
      if (i == 2 || i == 3) chk({columnOut[i-2].powerOn, columnOut[i-2].lowRange,
        columnOut[i-2].sampleHold, columnOut[i-2].rampDrive && !(d[0] && d[2])},
        {d[0], d[6], d[5] && d[0] && (!d[2] || columnOut[i-2].rampDrive),
        1'b0});
    end
    $display("register test done");
    wr(`SAP_IDX_GATE_CTRL, 8'h10);
    wr(`SAP_IDX_GATE_SRC, 8'h00);
    for (int h = 1; h <= 5; h++) for (int l = 0; l < 4; l++) begin
      wr(`SAP_IDX_PWM, {2'h0, 3'(h), 2'(l), 1'b1});
      gap(0, g);
      chk(g, ((1 << (h - 1)) + l) * 4);
      chk(hiT, (1 << (h - 1)) * 4);
    end
    wr(`SAP_IDX_COL_A, 8'h01);
    comparatorIn <= 2'h3;
    repeat (160) @(posedge clock);
    rdr(`SAP_IDX_COL_A);
    chk(rd[7], 1'b1);
    comparatorIn <= 2'h0;
    repeat (160) @(posedge clock);
    rdr(`SAP_IDX_COL_A);
    chk(rd[7], 1'b0);
    wr(`SAP_IDX_COL_A, 8'h09);
    gap(0, g);
    c0 = captureCount;
    repeat (10 * g) @(negedge clock);
    chk(captureCount - c0, 16'h000A);
    wr(`SAP_IDX_PWM, 8'h08);
    repeat (20) @(posedge clock);
    chk(conversionPwm, 1'b0);
    wr(`SAP_IDX_PWM, 8'h00);
    wr(`SAP_IDX_GATE_SRC, 8'h02);
    wr(`SAP_IDX_COL_A, 8'h05);
    repeat (20) begin
      @(negedge clock);
      g = digitalGate[2];
      @(negedge clock);
      chk(columnOut[0].rampDrive, g);
    end
    $display("pwm test done");
    for (int s = 0; s < 4; s++) for (int v = 0; v < 4; v++) begin
      wr(`SAP_IDX_CLK_SEL, {4'h0, 2'(3 - s), 2'(s)});
      wr(`SAP_IDX_CLK_DIV, {2'h0, 2'(v), 2'h0, 2'(v)});
      gap(1, g);
      chk(g, (4 << s) << v);
      gap(2, g);
      chk(g, (4 << (3 - s)) << v);
      wr(`SAP_IDX_CLK_DIV, {2'h1, 2'(v), 2'h1, 2'(v)});
      gap(1, g);
      chk(g, 1 << v);
    end
    $display("column clock test done");
    finishTest();
  end
endmodule

// ### sap_defines.svh
// register indices, field positions, masks and reset values of the converter control block
// assumes: byte address of a register is four times its index on a 32-bit register bus
`ifndef SAP_DEFINES_SVH
`define SAP_DEFINES_SVH

// register indices (byte address = index * 4)
`define SAP_IDX_MODULATOR 8'h83
`define SAP_IDX_PWM 8'h85
`define SAP_IDX_COL_A 8'h86
`define SAP_IDX_COL_B 8'h87
`define SAP_IDX_CLK_SEL 8'h89
`define SAP_IDX_CLK_DIV 8'h8B
`define SAP_IDX_GATE_CTRL 8'h8C
`define SAP_IDX_GATE_SRC 8'h8D

// writable bit masks; reserved bits are stored and read as zero
`define SAP_MASK_MODULATOR 8'h0F
`define SAP_MASK_PWM 8'h3F
`define SAP_MASK_COL 8'h6D
`define SAP_MASK_CLK_SEL 8'h0F
`define SAP_MASK_CLK_DIV 8'h77
`define SAP_MASK_GATE_CTRL 8'hF0
`define SAP_MASK_GATE_SRC 8'h03
`define SAP_REG_RESET 8'h00

// conversion pwm control fields
`define SAP_PWM_EN_BIT 0
`define SAP_PWM_LOW_LSB 1
`define SAP_PWM_ON_LSB 3

// column converter config fields
`define SAP_COL_END_BIT 7
`define SAP_COL_RANGE_BIT 6
`define SAP_COL_SH_BIT 5
`define SAP_COL_BUS_BIT 3
`define SAP_COL_AUTO_BIT 2
`define SAP_COL_PWR_BIT 0

// gate enables and clock divider nibble layout
`define SAP_GATE_EN_LSB 4
`define SAP_DIV_SYS_BIT 2

// bus responses
`define SAP_RESP_OKAY 2'h0
`define SAP_RESP_SLVERR 2'h2

`endif

// ### sap_pkg.sv
// types shared by the converter control block and its column clock divider
// assumes: sap_defines.svh supplies the numeric constants
package sap_pkg;

  // dedicated conversion pwm phases
  typedef enum logic [1:0] {
    SAP_PWM_IDLE = 2'h0,
    SAP_PWM_HIGH = 2'h1,
    SAP_PWM_LOW = 2'h2
  } sap_pwm_state_t;

  // register selected by a bus address
  typedef enum logic [3:0] {
    SAP_REG_NONE = 4'h0,
    SAP_REG_MODULATOR = 4'h1,
    SAP_REG_PWM = 4'h2,
    SAP_REG_COL_A = 4'h3,
    SAP_REG_COL_B = 4'h4,
    SAP_REG_CLK_SEL = 4'h5,
    SAP_REG_CLK_DIV = 4'h6,
    SAP_REG_GATE_CTRL = 4'h7,
    SAP_REG_GATE_SRC = 4'h8
  } sap_reg_t;

  // per-column drive toward the analog column and comparator bus
  typedef struct packed {
    logic powerOn;
    logic lowRange;
    logic sampleHold;
    logic rampDrive;
    logic busOut;
  } sap_column_out_t;

  // column clock divider state
  typedef struct packed {
    logic [2:0] count;
    logic tick;
  } sap_div_state_t;

  // whole state of the converter control block
  typedef struct packed {
    logic [7:0] modSel;
    logic [7:0] pwmCtrl;
    logic [1:0][7:0] adcCfg;
    logic [7:0] clkSel;
    logic [7:0] clkDiv;
    logic [7:0] gateCtrl;
    logic [7:0] gateSrc;
    logic [1:0] endState;
    logic [1:0] tripSeen;
    logic [1:0] cmpSync;
    sap_column_out_t [1:0] colOut;
    sap_pwm_state_t pwmState;
    logic [4:0] spanCnt;
    logic pwmLevel;
    logic pwmTc;
    logic vc3Prev;
    logic gatePrev;
    logic [3:0] srcPrev;
    logic awHeld;
    logic wHeld;
    logic [11:0] awAddr;
    logic [7:0] wData;
    logic wStrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } sap_state_t;

endpackage
